// File: rtl/mit_defs.svh
`ifndef MIT_DEFS_SVH
`define MIT_DEFS_SVH

// Clock and channel pacing
`define MIT_CLK_MHZ       100
`define MIT_FAST_NS       800
`define MIT_QUEUE_NS      7143
`define MIT_FAST_CYC      ((`MIT_FAST_NS * `MIT_CLK_MHZ + 999) / 1000)
`define MIT_QUEUE_CYC     ((`MIT_QUEUE_NS * `MIT_CLK_MHZ + 999) / 1000)

// Translation buffer geometry
`define MIT_ENTRIES       64
`define MIT_IDX_W         6
`define MIT_PPN_W         12
`define MIT_LEAF_MAX_W    3
`define MIT_PAGE_LSB      10
`define MIT_SEG_LSB       16
`define MIT_PADDR_W       22

// Register byte offsets
`define MIT_CTRL_OFF      8'h00
`define MIT_CWORD_OFF     8'h04
`define MIT_LOAD_OFF      8'h08
`define MIT_ENTRY_OFF     8'h0c
`define MIT_STATUS_OFF    8'h10

// Control register fields
`define MIT_CTRL_START    0
`define MIT_CTRL_TOMEM    1
`define MIT_CTRL_QUEUED   2

// Control word fields
`define MIT_CW_CNT_LSB    20
`define MIT_CW_CNT_W      12
`define MIT_CW_OFF_W      18

// Load and entry register fields
`define MIT_LD_IDX_LSB    16
`define MIT_LD_VALID      31
`define MIT_EN_LEAF_LSB   24

// Status register fields
`define MIT_ST_BUSY       0
`define MIT_ST_FAULT      1
`define MIT_ST_DONE       2
`define MIT_ST_CNT_LSB    16

// Reset values
`define MIT_CWORD_RST     32'h0000_0000
`define MIT_CTRL_RST      2'h0

`endif

// File: rtl/mit_pkg.sv
package mit_pkg;
    `include "mit_defs.svh"

    typedef struct packed {
        logic                          valid;
        logic [`MIT_LEAF_MAX_W-1:0]    leaf;
        logic [`MIT_PPN_W-1:0]         ppn;
    } mit_entry_t;

    typedef enum logic [1:0] {
        MIT_IDLE,
        MIT_LOOK,
        MIT_ISSUE,
        MIT_GAP
    } mit_state_t;
endpackage

// File: rtl/mit_tbuf_if.sv
`timescale 1ns/1ps
`include "mit_defs.svh"
interface mit_tbuf_if;
    import mit_pkg::*;
    logic                   wr_en;
    logic [`MIT_IDX_W-1:0]  wr_idx;
    mit_entry_t             wr_entry;
    logic [`MIT_IDX_W-1:0]  rd_idx_a;
    mit_entry_t             rd_a;
    logic [`MIT_IDX_W-1:0]  rd_idx_b;
    mit_entry_t             rd_b;

    modport owner (input wr_en, wr_idx, wr_entry, rd_idx_a, rd_idx_b, output rd_a, rd_b);
    modport user  (output wr_en, wr_idx, wr_entry, rd_idx_a, rd_idx_b, input rd_a, rd_b);
endinterface

// File: rtl/mit_tbuf.sv
`timescale 1ns/1ps
`include "mit_defs.svh"
module mit_tbuf
    import mit_pkg::*;
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Entry access
    mit_tbuf_if.owner tb
);
    logic [`MIT_PPN_W-1:0]      ppn_mem  [`MIT_ENTRIES];  // RULE1 RULE2
    logic [`MIT_LEAF_MAX_W-1:0] leaf_mem [`MIT_ENTRIES];
    logic [`MIT_ENTRIES-1:0]    valid_q;
    logic [`MIT_ENTRIES-1:0]    valid_d;

    // Only the valid bits are reset; stale page numbers are harmless behind them
    always_comb begin
        valid_d = valid_q;
        if (tb.wr_en) begin
            valid_d[tb.wr_idx] = tb.wr_entry.valid;  // RULE3
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            valid_q <= '0;
        end else begin
            valid_q <= valid_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (tb.wr_en) begin
            ppn_mem[tb.wr_idx]  <= tb.wr_entry.ppn;  // RULE2
            leaf_mem[tb.wr_idx] <= tb.wr_entry.leaf;
        end
    end

    assign tb.rd_a = '{valid: valid_q[tb.rd_idx_a], leaf: leaf_mem[tb.rd_idx_a],
                       ppn: ppn_mem[tb.rd_idx_a]};
    assign tb.rd_b = '{valid: valid_q[tb.rd_idx_b], leaf: leaf_mem[tb.rd_idx_b],
                       ppn: ppn_mem[tb.rd_idx_b]};

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    entry_valid_a: assert property (tb.wr_en |=> valid_q[$past(tb.wr_idx)] == $past(tb.wr_entry.valid)) // RULE3
        else $error("entry valid bit not stored");
    entry_ppn_a: assert property (tb.wr_en |=> ppn_mem[$past(tb.wr_idx)] == $past(tb.wr_entry.ppn)) // RULE2
        else $error("entry page number not stored");
endmodule

// File: rtl/mit_top.sv
// Notes on behaviour
// RULE1 - The translation buffer holds exactly 64 entries.
// RULE2 - Every entry keeps a 12-bit physical page number.
// RULE3 - Every entry keeps one valid bit marking current or stale contents.
// RULE4 - Leaf field is 3 bits for 8 leaves, 2 for 4, none for one.
// RULE5 - Only segment 0 is mapped; entry n maps page n.
// RULE6 - Leaf bits from the virtual address pick the cache leaf to invalidate.
// RULE7 - A memory write invalidates only the one cache location it touched.
// RULE8 - Multi-leaf variants: software loads entries by a load instruction first.
// RULE9 - One-leaf variants: an instruction access to a segment 0 page loads it.
// RULE10 - Mapped control word: two's-complement count, reserved field, start offset.
// RULE11 - Fast channel paced to 2.5 Mbytes/s, queued channel to 280 Kbytes/s.
// RULE12 - Physical address joins entry page number with virtual page offset.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "mit_defs.svh"
module mit_top
    import mit_pkg::*;
#(
    parameter int LEAF_COUNT = 8
) (
    // Clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]               s_awaddr,
    input  wire logic                     s_awvalid,
    output logic                          s_awready,
    input  wire logic [31:0]              s_wdata,
    input  wire logic [3:0]               s_wstrb,
    input  wire logic                     s_wvalid,
    output logic                          s_wready,
    output logic [1:0]                    s_bresp,
    output logic                          s_bvalid,
    input  wire logic                     s_bready,
    // AXI4-Lite read
    input  wire logic [7:0]               s_araddr,
    input  wire logic                     s_arvalid,
    output logic                          s_arready,
    output logic [31:0]                   s_rdata,
    output logic [1:0]                    s_rresp,
    output logic                          s_rvalid,
    input  wire logic                     s_rready,
    // Instruction access side-load (one-leaf variant)
    input  wire logic                     fetch_valid,
    input  wire logic [`MIT_CW_OFF_W-1:0] fetch_vaddr,
    input  wire logic [`MIT_PPN_W-1:0]    fetch_ppn,
    // Memory transfer request
    output logic                          dm_valid,
    input  wire logic                     dm_ready,
    output logic [`MIT_PADDR_W-1:0]       dm_addr,
    output logic                          dm_write,
    // Cache invalidate
    output logic                          inval_valid,
    output logic [`MIT_PADDR_W-1:0]       inval_addr,
    output logic [`MIT_LEAF_MAX_W-1:0]    inval_leaf
);
    localparam int LEAF_W = (LEAF_COUNT >= 8) ? 3 : (LEAF_COUNT >= 4) ? 2 : 0;  // RULE4
    localparam logic [`MIT_LEAF_MAX_W-1:0] LEAF_MASK = `MIT_LEAF_MAX_W'((1 << LEAF_W) - 1);
    localparam logic [9:0] FAST_GAP  = 10'(`MIT_FAST_CYC - 3);
    localparam logic [9:0] QUEUE_GAP = 10'(`MIT_QUEUE_CYC - 3);
    localparam int FAST_MIN = `MIT_FAST_CYC;
    localparam int QUEUE_MIN = `MIT_QUEUE_CYC;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Leaf bits come from the low virtual page bits, trimmed to the cache organisation
    function automatic logic [`MIT_LEAF_MAX_W-1:0] leaf_of(input logic [`MIT_CW_OFF_W-1:0] va);
        return va[`MIT_PAGE_LSB +: `MIT_LEAF_MAX_W] & LEAF_MASK;  // RULE4 RULE6
    endfunction

    function automatic logic in_seg0(input logic [`MIT_CW_OFF_W-1:0] va);
        return va[`MIT_CW_OFF_W-1:`MIT_SEG_LSB] == '0;
    endfunction

    mit_tbuf_if tb ();

    mit_tbuf u_tbuf (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tb      (tb.owner)
    );

    // Bus slave state
    logic                      aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0]                aw_addr_q, aw_addr_d;
    logic [31:0]               w_data_q, w_data_d;
    logic [3:0]                w_strb_q, w_strb_d;
    logic                      bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]                bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]               rdata_q, rdata_d;
    logic [31:0]               cword_q, cword_d;
    logic [1:0]                ctrl_q, ctrl_d;
    logic [`MIT_IDX_W-1:0]     sel_q, sel_d;
    logic                      wr_fire, start;
    logic [31:0]               wval;

    // Transfer engine state
    mit_state_t                st_q, st_d;
    logic [`MIT_CW_CNT_W-1:0]  cnt_q, cnt_d;
    logic [`MIT_CW_OFF_W-1:0]  va_q, va_d;
    logic [9:0]                gap_q, gap_d;
    logic                      fault_q, fault_d, done_q, done_d;
    logic                      dm_valid_q, dm_valid_d;
    logic [`MIT_PADDR_W-1:0]   dm_addr_q, dm_addr_d;
    logic [`MIT_LEAF_MAX_W-1:0] leaf_q, leaf_d;
    logic                      inv_q, inv_d;
    logic [`MIT_PADDR_W-1:0]   inv_addr_q, inv_addr_d;
    logic [`MIT_LEAF_MAX_W-1:0] inv_leaf_q, inv_leaf_d;
    logic [`MIT_CW_CNT_W-1:0]  cnt_inc;

    assign s_awready = !aw_have_q && !bvalid_q;
    assign s_wready  = !w_have_q && !bvalid_q;
    assign s_arready = !rvalid_q;
    assign wr_fire   = aw_have_q && w_have_q;
    assign wval      = merge(32'h0000_0000, w_data_q, w_strb_q);
    assign start     = wr_fire && aw_addr_q == `MIT_CTRL_OFF && w_strb_q[0]
                       && w_data_q[`MIT_CTRL_START] && st_q == MIT_IDLE;

    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q && !s_bready;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q && !s_rready;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        cword_d   = cword_q;
        ctrl_d    = ctrl_q;
        sel_d     = sel_q;
        tb.wr_en    = 1'b0;
        tb.wr_idx   = sel_q;
        tb.wr_entry = '0;
        if (s_awvalid && s_awready) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            w_have_d = 1'b1;
            w_data_d = s_wdata;
            w_strb_d = s_wstrb;
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = 2'b00;
            unique case (aw_addr_q)
                `MIT_CTRL_OFF: begin
                    if (w_strb_q[0]) begin
                        ctrl_d = w_data_q[`MIT_CTRL_QUEUED:`MIT_CTRL_TOMEM];
                    end
                end
                `MIT_CWORD_OFF: cword_d = merge(cword_q, w_data_q, w_strb_q);  // RULE10
                `MIT_LOAD_OFF: begin
                    sel_d = wval[`MIT_LD_IDX_LSB +: `MIT_IDX_W];
                    // Explicit loads exist only where the cache spans several leaves
                    if (LEAF_COUNT > 1) begin
                        tb.wr_en    = 1'b1;  // RULE8
                        tb.wr_idx   = wval[`MIT_LD_IDX_LSB +: `MIT_IDX_W];  // RULE5
                        tb.wr_entry = '{valid: wval[`MIT_LD_VALID],
                                        leaf: wval[`MIT_LD_IDX_LSB +: `MIT_LEAF_MAX_W] & LEAF_MASK,
                                        ppn: wval[`MIT_PPN_W-1:0]};
                    end
                end
                `MIT_ENTRY_OFF: sel_d = wval[`MIT_IDX_W-1:0];
                `MIT_STATUS_OFF: ;
                default: bresp_d = 2'b10;
            endcase
        end
        // Register loads win; both sources never coexist in one variant
        if (!tb.wr_en && LEAF_COUNT == 1 && fetch_valid && in_seg0(fetch_vaddr)) begin
            tb.wr_en    = 1'b1;  // RULE9
            tb.wr_idx   = fetch_vaddr[`MIT_PAGE_LSB +: `MIT_IDX_W];  // RULE5
            tb.wr_entry = '{valid: 1'b1, leaf: '0, ppn: fetch_ppn};
        end
        if (s_arvalid && s_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = 2'b00;
            unique case (s_araddr)
                `MIT_CTRL_OFF:   rdata_d = {29'h0, ctrl_q, 1'b0};
                `MIT_CWORD_OFF:  rdata_d = cword_q;
                `MIT_LOAD_OFF:   rdata_d = {10'h0, sel_q, 16'h0};
                `MIT_ENTRY_OFF:  rdata_d = {tb.rd_b.valid, 4'h0, tb.rd_b.leaf, 2'h0, sel_q,
                                            4'h0, tb.rd_b.ppn};
                `MIT_STATUS_OFF: rdata_d = {4'h0, cnt_q, 13'h0, done_q, fault_q,
                                            st_q != MIT_IDLE};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = 2'b10;
                end
            endcase
        end
    end

    assign tb.rd_idx_a = va_q[`MIT_PAGE_LSB +: `MIT_IDX_W];  // RULE5
    assign tb.rd_idx_b = sel_q;
    assign cnt_inc     = cnt_q + `MIT_CW_CNT_W'(1);

    always_comb begin
        st_d       = st_q;
        cnt_d      = cnt_q;
        va_d       = va_q;
        gap_d      = gap_q;
        fault_d    = fault_q;
        done_d     = done_q;
        dm_valid_d = dm_valid_q;
        dm_addr_d  = dm_addr_q;
        leaf_d     = leaf_q;
        inv_d      = 1'b0;
        inv_addr_d = inv_addr_q;
        inv_leaf_d = inv_leaf_q;
        unique case (st_q)
            MIT_IDLE: begin
                if (start) begin
                    fault_d = 1'b0;
                    done_d  = 1'b0;
                    cnt_d   = cword_q[`MIT_CW_CNT_LSB +: `MIT_CW_CNT_W];  // RULE10
                    va_d    = cword_q[`MIT_CW_OFF_W-1:0];
                    if (cword_q[`MIT_CW_CNT_LSB +: `MIT_CW_CNT_W] == '0) begin
                        done_d = 1'b1;
                    end else begin
                        st_d = MIT_LOOK;
                    end
                end
            end
            MIT_LOOK: begin
                // Outside segment 0 or a stale entry stops the transfer
                if (!in_seg0(va_q) || !tb.rd_a.valid) begin
                    fault_d = 1'b1;  // RULE5 RULE3
                    done_d  = 1'b1;
                    st_d    = MIT_IDLE;
                end else begin
                    dm_addr_d  = {tb.rd_a.ppn, va_q[`MIT_PAGE_LSB-1:0]};  // RULE12
                    leaf_d     = leaf_of(va_q);  // RULE6
                    dm_valid_d = 1'b1;
                    st_d       = MIT_ISSUE;
                end
            end
            MIT_ISSUE: begin
                if (dm_ready) begin
                    dm_valid_d = 1'b0;
                    if (ctrl_q[0]) begin
                        inv_d      = 1'b1;  // RULE7
                        inv_addr_d = dm_addr_q;
                        inv_leaf_d = leaf_q;
                    end
                    cnt_d = cnt_inc;
                    va_d  = va_q + `MIT_CW_OFF_W'(1);
                    if (cnt_inc == '0) begin
                        done_d = 1'b1;
                        st_d   = MIT_IDLE;
                    end else begin
                        gap_d = ctrl_q[1] ? QUEUE_GAP : FAST_GAP;  // RULE11
                        st_d  = MIT_GAP;
                    end
                end
            end
            MIT_GAP: begin
                if (gap_q == '0) begin
                    st_d = MIT_LOOK;
                end else begin
                    gap_d = gap_q - 10'h001;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q  <= 1'b0;
            aw_addr_q  <= 8'h00;
            w_have_q   <= 1'b0;
            w_data_q   <= 32'h0000_0000;
            w_strb_q   <= 4'h0;
            bvalid_q   <= 1'b0;
            bresp_q    <= 2'b00;
            rvalid_q   <= 1'b0;
            rresp_q    <= 2'b00;
            rdata_q    <= 32'h0000_0000;
            cword_q    <= `MIT_CWORD_RST;
            ctrl_q     <= `MIT_CTRL_RST;
            sel_q      <= '0;
            st_q       <= MIT_IDLE;
            cnt_q      <= '0;
            va_q       <= '0;
            gap_q      <= '0;
            fault_q    <= 1'b0;
            done_q     <= 1'b0;
            dm_valid_q <= 1'b0;
            dm_addr_q  <= '0;
            leaf_q     <= '0;
            inv_q      <= 1'b0;
            inv_addr_q <= '0;
            inv_leaf_q <= '0;
        end else begin
            aw_have_q  <= aw_have_d;
            aw_addr_q  <= aw_addr_d;
            w_have_q   <= w_have_d;
            w_data_q   <= w_data_d;
            w_strb_q   <= w_strb_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            rvalid_q   <= rvalid_d;
            rresp_q    <= rresp_d;
            rdata_q    <= rdata_d;
            cword_q    <= cword_d;
            ctrl_q     <= ctrl_d;
            sel_q      <= sel_d;
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            va_q       <= va_d;
            gap_q      <= gap_d;
            fault_q    <= fault_d;
            done_q     <= done_d;
            dm_valid_q <= dm_valid_d;
            dm_addr_q  <= dm_addr_d;
            leaf_q     <= leaf_d;
            inv_q      <= inv_d;
            inv_addr_q <= inv_addr_d;
            inv_leaf_q <= inv_leaf_d;
        end
    end

    assign s_bvalid    = bvalid_q;
    assign s_bresp     = bresp_q;
    assign s_rvalid    = rvalid_q;
    assign s_rresp     = rresp_q;
    assign s_rdata     = rdata_q;
    assign dm_valid    = dm_valid_q;
    assign dm_addr     = dm_addr_q;
    assign dm_write    = ctrl_q[0];
    assign inval_valid = inv_q;
    assign inval_addr  = inv_addr_q;
    assign inval_leaf  = inv_leaf_q;

    // Cycles since the last accepted memory request, for pacing checks
    logic [11:0] since_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || (dm_valid_q && dm_ready)) begin
            since_q <= 12'h000;
        end else if (since_q != 12'hfff) begin
            since_q <= since_q + 12'h001;
        end
    end
    logic seen_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || start) begin
            seen_q <= 1'b0;
        end else if (dm_valid_q && dm_ready) begin
            seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    phys_join_a: assert property (st_q == MIT_LOOK && in_seg0(va_q) && tb.rd_a.valid |=> // RULE12
        dm_valid_q && dm_addr_q == {$past(tb.rd_a.ppn), $past(va_q[`MIT_PAGE_LSB-1:0])})
        else $error("physical address not formed from entry and offset");
    seg_zero_a: assert property (st_q == MIT_LOOK && !in_seg0(va_q) |=> // RULE5
        st_q == MIT_IDLE && fault_q && !dm_valid_q)
        else $error("address outside segment 0 not faulted");
    stale_entry_a: assert property (st_q == MIT_LOOK && !tb.rd_a.valid |=> fault_q [*2]) // RULE3
        else $error("stale entry did not fault");
    inval_one_a: assert property (dm_valid_q && dm_ready && dm_write |=> inval_valid && // RULE7
        inval_addr == $past(dm_addr_q) && inval_leaf == $past(leaf_q) ##1 !inval_valid)
        else $error("invalidate not a single pulse for the written location");
    no_read_inval_a: assert property (dm_valid_q && dm_ready && !dm_write |=> !inval_valid) // RULE7
        else $error("invalidate issued for a read transfer");
    leaf_width_a: assert property (inval_valid |-> (inval_leaf & ~LEAF_MASK) == '0) // RULE4
        else $error("leaf bits wider than cache organisation");
    fast_pace_a: assert property (dm_valid_q && dm_ready && seen_q && !ctrl_q[1] |-> // RULE11
        since_q >= 12'(FAST_MIN - 1))
        else $error("fast channel exceeded its rate");
    queue_pace_a: assert property (dm_valid_q && dm_ready && seen_q && ctrl_q[1] |-> // RULE11
        since_q >= 12'(QUEUE_MIN - 1))
        else $error("queued channel exceeded its rate");
    cword_load_a: assert property (start |=> // RULE10
        cnt_q == $past(cword_q[`MIT_CW_CNT_LSB +: `MIT_CW_CNT_W]) &&
        va_q == $past(cword_q[`MIT_CW_OFF_W-1:0]))
        else $error("control word fields not taken at start");
    side_load_a: assert property (LEAF_COUNT == 1 && fetch_valid && in_seg0(fetch_vaddr) |-> // RULE9
        tb.wr_en && tb.wr_entry.valid)
        else $error("instruction access did not load the entry");
    req_hold_a: assert property (dm_valid_q && !dm_ready |=> dm_valid_q && $stable(dm_addr_q))
        else $error("memory request dropped before acceptance");

    write_cov_c: cover property (dm_valid_q && dm_ready && dm_write ##1 inval_valid);
    fault_cov_c: cover property (st_q == MIT_LOOK ##1 fault_q);
    done_cov_c:  cover property (st_q == MIT_ISSUE && dm_ready && cnt_inc == '0);
endmodule

// File: test/mit_mem.sv
`timescale 1ns/1ps
`include "mit_defs.svh"
module mit_mem (
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // Memory side
    input  wire logic                       slow,
    input  wire logic                       dm_valid,
    output logic                            dm_ready,
    input  wire logic [`MIT_PADDR_W-1:0]    dm_addr,
    // Cache side
    input  wire logic                       inval_valid,
    input  wire logic [`MIT_PADDR_W-1:0]    inval_addr,
    input  wire logic [`MIT_LEAF_MAX_W-1:0] inval_leaf
);
    logic [15:0]                hs, iv;
    logic [31:0]                cyc_q, t_q, gap;
    logic [2:0]                 wait_q;
    logic [`MIT_PADDR_W-1:0]    la, ia;
    logic [`MIT_LEAF_MAX_W-1:0] il;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {dm_ready, wait_q, hs, iv, cyc_q, t_q, gap, la, ia, il} <= '0;
        end else begin
            cyc_q <= cyc_q + 32'h1;
            // Slow mode stalls three cycles to stretch the channel
            dm_ready <= dm_valid && !dm_ready && (!slow || wait_q == 3'h3);
            wait_q <= (dm_valid && !dm_ready) ? wait_q + 3'h1 : 3'h0;
            if (dm_valid && dm_ready) begin
                hs <= hs + 16'h1;
                la <= dm_addr;
                gap <= cyc_q - t_q;
                t_q <= cyc_q;
            end
            if (inval_valid) begin
                iv <= iv + 16'h1;
                ia <= inval_addr;
                il <= inval_leaf;
            end
        end
    end
endmodule

// File: test/tb_mapped_io_translation.sv
`timescale 1ns/1ps
`include "mit_defs.svh"
module tb_mapped_io_translation;
    logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0;
    logic [3:0] s_wstrb = 4'hf;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, dm_valid, dm_ready, dm_write;
    logic inval_valid;
    logic [1:0] s_bresp, s_rresp;
    logic [31:0] s_rdata;
    logic [21:0] dm_addr, inval_addr;
    logic [2:0] inval_leaf;
    int err_count = 0, total_checks = 0, cyc = 0;
    always #5 aclk = ~aclk;
    mit_top mit_top_i (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready(1'b1),
        .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready(1'b1),
        .fetch_valid(1'b0), .fetch_vaddr(18'h00000), .fetch_ppn(12'h000), .dm_valid,
        .dm_ready, .dm_addr, .dm_write, .inval_valid, .inval_addr, .inval_leaf);
    mit_mem mit_mem_i (.aclk, .aresetn, .slow, .dm_valid, .dm_ready, .dm_addr,
        .inval_valid, .inval_addr, .inval_leaf);
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Far too many cycles for every scenario means a hang
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            close_out;
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok, b_ok;
        logic [1:0] br;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        // Judge handshakes mid-cycle, so the edge's own register updates cannot race us
        do begin
            @(negedge aclk);
            aw_ok = s_awvalid && s_awready;
            w_ok = s_wvalid && s_wready;
            b_ok = s_bvalid === 1'b1;
            br = s_bresp;
            @(posedge aclk);
            if (aw_ok) s_awvalid <= 1'b0;
            if (w_ok) s_wvalid <= 1'b0;
        end while (!b_ok);
        chk("bresp", {30'h0, br}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_ok, r_ok;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ar_ok = s_arvalid && s_arready;
            r_ok = s_rvalid === 1'b1;
            d = s_rdata;
            r = s_rresp;
            @(posedge aclk);
            if (ar_ok) s_arvalid <= 1'b0;
        end while (!r_ok);
    endtask
    task automatic wait_done(output logic [31:0] st);
        logic [1:0] r;
        int n;
        n = 0;
        do begin
            rd(`MIT_STATUS_OFF, st, r);
            n++;
        end while (st[2] !== 1'b1 && n < 3000);
    endtask
    task automatic regs_test;
        logic [31:0] d;
        logic [1:0] r;
        rd(`MIT_CTRL_OFF, d, r);
        chk("ctrl reset", d, 32'h0);
        rd(`MIT_CWORD_OFF, d, r);
        chk("cword reset", d, 32'h0);
        rd(8'h14, d, r);
        chk("unmapped rresp", {30'h0, r}, 32'h2);
        wr(8'h14, 32'hffff_ffff, 2'h2);
        wr(`MIT_LOAD_OFF, 32'h803f_0123, 2'h0);
        rd(`MIT_ENTRY_OFF, d, r);
        chk("last entry", d, 32'h873f_0123);
        wr(`MIT_ENTRY_OFF, 32'h5, 2'h0);
        rd(`MIT_ENTRY_OFF, d, r);
        chk("stale entry", d & 32'h803f_0000, 32'h0005_0000);
        wr(`MIT_CWORD_OFF, 32'hffe0_1410, 2'h0);
        rd(`MIT_CWORD_OFF, d, r);
        chk("cword", d, 32'hffe0_1410);
        s_wstrb <= 4'h3;
        wr(`MIT_CWORD_OFF, 32'h1234_5678, 2'h0);
        s_wstrb <= 4'hf;
        rd(`MIT_CWORD_OFF, d, r);
        chk("cword merge", d, 32'hffe0_5678);
    endtask
    // Two words from page 5 offset 0x10, mapped to physical page 0xabc
    task automatic xfer(input logic q, input logic sl, input logic wm, input int gmin);
        logic [31:0] st;
        logic [15:0] h0, i0;
        slow <= sl;
        h0 = mit_mem_i.hs;
        i0 = mit_mem_i.iv;
        wr(`MIT_LOAD_OFF, 32'h8005_0abc, 2'h0);
        wr(`MIT_CWORD_OFF, 32'hffe0_1410, 2'h0);
        wr(`MIT_CTRL_OFF, {29'h0, q, wm, 1'b1}, 2'h0);
        wait_done(st);
        chk("status", st, 32'h4);
        chk("words", {16'h0, mit_mem_i.hs - h0}, 32'h2);
        chk("phys addr", {10'h0, mit_mem_i.la}, {10'h0, 12'habc, 10'h011});
        chk("invals", {16'h0, mit_mem_i.iv - i0}, wm ? 32'h2 : 32'h0);
        chk("inval addr", {10'h0, mit_mem_i.ia}, {10'h0, 12'habc, 10'h011});
        chk("inval leaf", {29'h0, mit_mem_i.il}, 32'h5);
        chk("spacing", {31'h0, mit_mem_i.gap >= gmin}, 32'h1);
    endtask
    task automatic fault_test;
        logic [31:0] st;
        logic [15:0] h0;
        h0 = mit_mem_i.hs;
        // Stale page, segment 1, then a zero count that must finish without a word
        for (int i = 0; i < 3; i++) begin
            wr(`MIT_CWORD_OFF, (i == 0) ? 32'hfff0_1c00 : (i == 1) ? 32'hfff1_0000 :
               32'h0000_1410, 2'h0);
            wr(`MIT_CTRL_OFF, 32'h1, 2'h0);
            wait_done(st);
            chk("fault", st & 32'h7, (i == 2) ? 32'h4 : 32'h6);
        end
        chk("no words", {16'h0, mit_mem_i.hs - h0}, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        regs_test();
        xfer(1'b0, 1'b0, 1'b1, 80);
        xfer(1'b0, 1'b1, 1'b0, 80);
        xfer(1'b1, 1'b0, 1'b1, 715);
        fault_test();
        close_out;
    end
endmodule
